// ---- hdl/scg_pkg.sv ----
// Constants, field layouts and carrier types for the system clock generator.
// Assumes a single 20 MHz fabric clock that samples every oscillator tick.
package scg_pkg;

  // ==========================================================================
  // Fabric clock and timing
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS    = 50;
  localparam int unsigned WAKE_EXTRA_NS    = 60000;
  localparam int unsigned WAKE_EXTRA_CYC   = (WAKE_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] WAKE_XTAL_OSC    = 11'h3E0;
  localparam logic [10:0] WAKE_OTHER_OSC   = 11'h0E0;
  localparam logic [10:0] WAKE_EXTRA_CNT   = 11'(WAKE_EXTRA_CYC);

  // ==========================================================================
  // Nominal oscillator figures, kept for reference by software models
  // ==========================================================================
  localparam int unsigned RC_NOMINAL_HZ    = 7373000;
  localparam int unsigned WDT_NOMINAL_HZ   = 400000;
  localparam int unsigned XTAL_LOW_MAX_HZ  = 100000;
  localparam int unsigned XTAL_MED_MAX_HZ  = 4000000;
  localparam int unsigned XTAL_HIGH_MAX_HZ = 18000000;
  localparam int unsigned EXT_MAX_HZ       = 18000000;
  localparam int unsigned EXT_RESET_HZ     = 12000000;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_DIVIDER = 8'h95;
  localparam logic [7:0] ADDR_TUNE    = 8'h96;
  localparam logic [7:0] ADDR_STATUS  = 8'h97;

  localparam int unsigned TUNE_RC_SEL_BIT = 7;
  localparam int unsigned TUNE_CLKOUT_BIT = 6;
  localparam int unsigned TUNE_TRIM_MSB   = 5;
  localparam logic [7:0]  DIVIDER_RESET   = 8'h00;

  // ==========================================================================
  // Oscillator source codes held in the nonvolatile configuration
  // ==========================================================================
  typedef enum logic [2:0] {
    SRC_XTAL_LOW  = 3'h0,
    SRC_XTAL_MED  = 3'h1,
    SRC_XTAL_HIGH = 3'h2,
    SRC_RC        = 3'h3,
    SRC_WDT       = 3'h4,
    SRC_EXT       = 3'h7
  } scg_source_type;

  typedef enum logic [1:0] {
    W_OFF  = 2'b00,
    W_OSC  = 2'b01,
    W_TIME = 2'b10,
    W_RUN  = 2'b11
  } scg_wake_type;

  typedef struct packed {
    logic       rc_clock_select;
    logic       clock_out_enable;
    logic [5:0] trim;
  } scg_tune_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } scg_bus_req_type;

  typedef struct packed {
    logic wdt;
    logic rc;
    logic xtal;
    logic ext;
  } scg_osc_ticks_type;

  function automatic logic scg_is_crystal(input logic [2:0] code);
    return (code == SRC_XTAL_LOW) || (code == SRC_XTAL_MED) || (code == SRC_XTAL_HIGH);
  endfunction

endpackage

// ---- hdl/scg_divider.sv ----
// Programmable divider from oscillator ticks to CPU clock ticks.
// Assumes osc_tick is a one-cycle pulse and run gates every output tick.
`timescale 1ns/10ps
`default_nettype none
module scg_divider (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       osc_tick,
  input  wire logic       run,
  input  wire logic [7:0] factor,
  output var  logic       cpu_tick
);
  import scg_pkg::*;

  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } scg_div_state_type;

  scg_div_state_type s_reg;
  scg_div_state_type s_next;

  // ==========================================================================
  // Divide by twice the factor; a factor of zero passes ticks through.
  // ==========================================================================
  // The factor is compared on every oscillator tick, so software may change it on the fly
  // and the new ratio takes hold within the current period, which it cuts short or stretches.
  always_comb begin
    s_next      = s_reg;
    s_next.tick = 1'b0;
    if (!run) begin
      s_next.cnt = 9'h000;
    end else if (osc_tick) begin
      if (factor == 8'h00 || s_next.cnt >= {factor, 1'b0} - 9'h001) begin
        s_next.cnt  = 9'h000;
        s_next.tick = 1'b1;
      end else begin
        s_next.cnt = s_reg.cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cpu_tick = s_reg.tick;

endmodule
`default_nettype wire

// ---- hdl/scg_top.sv ----
// System clock generator: source select, wake-up timer, CPU and peripheral
// clock ticks, RC tuning register and clock output pin.
// Assumes all oscillators arrive as one-cycle ticks synchronous to clk, and
// rst_n is the power-on reset while sys_rst_n carries every other reset.
//
// Functional notes
// - A machine cycle is exactly two CPU clock ticks.
// - Oscillator clock comes from watchdog, RC, crystal or external source.
// - Source choice comes from nonvolatile configuration, latched at power-on only.
// - Peripheral clock runs at half the CPU clock.
// - RC oscillator is nominally 7.373 MHz and is one selectable source.
// - Crystal has low, medium and high bands.
// - Clock output allowed only when crystal feeds neither CPU nor RTC.
// - Clock output pin driven only while the output enable bit is set.
// - Clock output runs at half the CPU clock.
// - A six-bit tuning value adjusts the RC oscillator.
// - Tuning register takes factory value on power-on reset only.
// - Software may overwrite the tuning value at run time.
// - Tuning register: RC select bit 7, output enable bit 6, trim 5..0.
// - Crystal sources hold CPU clock 992 oscillator cycles plus 60 us.
// - Other sources hold CPU clock 224 oscillator cycles plus 60 us.
// - Watchdog oscillator is nominally 400 kHz and selectable.
// - External clock mode frees the crystal output pin for clock output.
// - CPU clock divides oscillator clock by up to 510, changeable anytime.
//
// Local design decision: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module scg_top (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       sys_rst_n,
  input  wire logic [2:0]                 config_source,
  input  wire logic [7:0]                 factory_tune,
  input  wire scg_pkg::scg_osc_ticks_type osc_ticks,
  input  wire logic                       rtc_uses_crystal,
  input  wire logic                       power_down,
  input  wire scg_pkg::scg_bus_req_type   bus_req,
  output var  logic [7:0]                 bus_rdata,
  output var  logic                       cpu_clock_tick,
  output var  logic                       machine_cycle_tick,
  output var  logic                       periph_clock_tick,
  output var  logic                       cpu_clock_running,
  output var  logic [7:0]                 rc_tune_value,
  output var  logic                       crystal_out_clock_pin_o,
  output var  logic                       crystal_out_clock_pin_oe
);
  import scg_pkg::*;

  typedef struct packed {
    scg_tune_type tune;
    logic [7:0]   divider;
    logic [2:0]   src;
    logic         por_load;
    scg_wake_type wake;
    logic [10:0]  wake_cnt;
    logic [7:0]   rdata;
    logic         phase;
    logic         mc_tick;
    logic         pclk_tick;
    logic         clk_out;
    logic         clk_out_oe;
    logic         running;
  } scg_state_type;

  scg_state_type s_reg;
  scg_state_type s_next;
  logic          osc_tick;
  logic          cpu_tick;
  logic          out_allowed;
  logic [10:0]   wake_target;

  // ==========================================================================
  // Source selection
  // ==========================================================================
  // Unknown configuration codes fall back to the RC oscillator so that a
  // badly programmed part still starts.
  always_comb begin
    unique case (s_reg.src)
      SRC_XTAL_LOW, SRC_XTAL_MED, SRC_XTAL_HIGH: osc_tick = osc_ticks.xtal;
      SRC_RC:  osc_tick = osc_ticks.rc;
      SRC_WDT: osc_tick = osc_ticks.wdt;
      SRC_EXT: osc_tick = osc_ticks.ext;
      default: osc_tick = osc_ticks.rc;
    endcase
  end

  assign wake_target = scg_is_crystal(s_reg.src) ? WAKE_XTAL_OSC : WAKE_OTHER_OSC;
  assign out_allowed = !scg_is_crystal(s_reg.src) && !rtc_uses_crystal;

  scg_divider u_divider (
    .clk      (clk),
    .rst_n    (rst_n),
    .osc_tick (osc_tick),
    .run      (s_reg.wake == W_RUN),
    .factor   (s_reg.divider),
    .cpu_tick (cpu_tick)
  );

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    s_next           = s_reg;
    s_next.por_load  = 1'b0;
    s_next.rdata     = 8'h00;
    s_next.mc_tick   = 1'b0;
    s_next.pclk_tick = 1'b0;

    // Configuration and factory tune are caught just after power-on release.
    if (s_reg.por_load) begin
      s_next.src  = config_source;
      s_next.tune = factory_tune;
    end

    // Wake-up timer: oscillator cycles first, then the fixed settle time.
    unique case (s_reg.wake)
      W_OFF: begin
        if (!s_reg.por_load && !power_down) begin
          s_next.wake     = W_OSC;
          s_next.wake_cnt = 11'h000;
        end
      end
      W_OSC: begin
        if (osc_tick) begin
          if (s_reg.wake_cnt == wake_target - 11'h001) begin
            s_next.wake     = W_TIME;
            s_next.wake_cnt = 11'h000;
          end else begin
            s_next.wake_cnt = s_reg.wake_cnt + 11'h001;
          end
        end
      end
      W_TIME: begin
        if (s_reg.wake_cnt == WAKE_EXTRA_CNT - 11'h001) begin
          s_next.wake = W_RUN;
        end else begin
          s_next.wake_cnt = s_reg.wake_cnt + 11'h001;
        end
      end
      W_RUN: begin
        s_next.wake_cnt = 11'h000;
      end
    endcase
    if (power_down) begin
      s_next.wake = W_OFF;
    end
    s_next.running = (s_next.wake == W_RUN);

    // Machine cycle and peripheral clock both fall on every second CPU tick.
    if (cpu_tick) begin
      s_next.phase     = !s_reg.phase;
      s_next.mc_tick   = s_reg.phase;
      s_next.pclk_tick = s_reg.phase;
    end

    // The pin toggles on each CPU tick, giving half the CPU frequency.
    s_next.clk_out_oe = s_reg.tune.clock_out_enable && out_allowed;
    if (!s_next.clk_out_oe) begin
      s_next.clk_out = 1'b0;
    end else if (cpu_tick) begin
      s_next.clk_out = !s_reg.clk_out;
    end

    // Register writes; a non-power-on reset never touches the tune value.
    if (!sys_rst_n) begin
      s_next.divider = DIVIDER_RESET;
    end else if (bus_req.wr) begin
      if (bus_req.addr == ADDR_TUNE) begin
        s_next.tune = bus_req.wdata;
      end
      if (bus_req.addr == ADDR_DIVIDER) begin
        s_next.divider = bus_req.wdata;
      end
    end

    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_TUNE:    s_next.rdata = s_reg.tune;
        ADDR_DIVIDER: s_next.rdata = s_reg.divider;
        ADDR_STATUS:  s_next.rdata = {3'h0, out_allowed, s_reg.wake, s_reg.src[2:1]};
        default:      s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg          <= '0;
      s_reg.por_load <= 1'b1;
      s_reg.src      <= SRC_RC;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign bus_rdata                = s_reg.rdata;
  assign cpu_clock_tick           = cpu_tick;
  assign machine_cycle_tick       = s_reg.mc_tick;
  assign periph_clock_tick        = s_reg.pclk_tick;
  assign cpu_clock_running        = s_reg.running;
  assign rc_tune_value            = s_reg.tune;
  assign crystal_out_clock_pin_o  = s_reg.clk_out;
  assign crystal_out_clock_pin_oe = s_reg.clk_out_oe;

  // ==========================================================================
  // Assertion helpers
  // ==========================================================================
  // The settle phase is timed by a counter of its own, so a wake_cnt that
  // stalls or skips cannot hide behind the count it is checked against.
  // Only the assertions read it, which is why it stays out of the state struct.
  logic [10:0] settle_cycles;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cycles <= 11'h000;
    end else if (s_reg.wake == W_TIME) begin
      settle_cycles <= settle_cycles + 11'h001;
    end else begin
      settle_cycles <= 11'h000;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_tune_por_load: assert property (s_reg.por_load |=> s_reg.tune == $past(factory_tune))
    else $error("tune not loaded from factory value after power-on");
  a_tune_kept: assert property (!sys_rst_n && !s_reg.por_load && !bus_req.wr |=>
    $stable(s_reg.tune))
    else $error("tune changed by a non power-on reset");
  a_source_fixed: assert property (!s_reg.por_load |=> $stable(s_reg.src))
    else $error("oscillator source changed at run time");
  a_wake_osc_count: assert property (s_reg.wake == W_TIME && $past(s_reg.wake) == W_OSC |->
    $past(s_reg.wake_cnt) == wake_target - 11'h001)
    else $error("wake-up oscillator count wrong");
  a_wake_settle: assert property (s_reg.wake == W_TIME |-> settle_cycles < WAKE_EXTRA_CNT)
    else $error("wake-up settle time overrun");
  a_settle_exit: assert property (s_reg.wake == W_RUN && $past(s_reg.wake) == W_TIME |->
    $past(settle_cycles) == WAKE_EXTRA_CNT - 11'h001)
    else $error("wake-up settle time too short");
  a_cpu_gated: assert property (s_reg.wake != W_RUN |=> !cpu_tick)
    else $error("CPU tick during wake-up delay");
  a_machine_cycle: assert property (cpu_tick && s_reg.phase |=> s_reg.mc_tick && s_reg.pclk_tick)
    else $error("machine cycle not on second CPU tick");
  a_periph_half: assert property (s_reg.pclk_tick |-> $past(cpu_tick) && !s_reg.phase)
    else $error("peripheral tick not at half CPU rate");
  a_clkout_gate: assert property (crystal_out_clock_pin_oe |->
    $past(s_reg.tune.clock_out_enable) && !$past(rtc_uses_crystal) &&
    !scg_is_crystal(s_reg.src))
    else $error("clock output driven while not allowed");
  a_clkout_rate: assert property ($changed(s_reg.clk_out) && s_reg.clk_out_oe |-> $past(cpu_tick))
    else $error("clock output toggled off a CPU tick");
  a_divider_write: assert property (bus_req.wr && sys_rst_n && bus_req.addr == ADDR_DIVIDER |=>
    s_reg.divider == $past(bus_req.wdata))
    else $error("divider write lost");

  // A tune write in the cycle of the factory load wins over it, so the load
  // check above expects software to keep off the bus in that one cycle.
  a_divider_sysrst: assert property (!sys_rst_n |=> s_reg.divider == DIVIDER_RESET)
    else $error("divider not cleared by system reset");
  a_divider_hold: assert property (sys_rst_n && !bus_req.wr |=> $stable(s_reg.divider))
    else $error("divider changed without a write");
  a_cpu_after_osc: assert property (cpu_tick |-> $past(osc_tick))
    else $error("CPU tick without an oscillator tick");
  a_tune_write: assert property (bus_req.wr && sys_rst_n && bus_req.addr == ADDR_TUNE |=>
    s_reg.tune == $past(bus_req.wdata))
    else $error("tune write lost");
  a_read_tune: assert property (bus_req.rd && bus_req.addr == ADDR_TUNE |=>
    bus_rdata == $past(s_reg.tune))
    else $error("tune read back wrong");
  a_read_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data not cleared after one cycle");
  a_clkout_idle: assert property (!crystal_out_clock_pin_oe |-> !crystal_out_clock_pin_o)
    else $error("clock output high while not driven");

  // Wake-up sequencing; power-down may cut any phase short.
  a_power_stop: assert property (power_down |=>
    s_reg.wake == W_OFF && !cpu_clock_running)
    else $error("wake-up state not reset by power-down");
  a_wake_start: assert property (s_reg.wake == W_OFF && !power_down && !s_reg.por_load |=>
    s_reg.wake == W_OSC)
    else $error("wake-up delay not started");
  a_wake_osc_hold: assert property (s_reg.wake == W_OSC && !osc_tick && !power_down |=>
    s_reg.wake == W_OSC && $stable(s_reg.wake_cnt))
    else $error("wake-up count moved without an oscillator tick");

  c_wake_done: cover property (s_reg.wake == W_TIME ##1 s_reg.wake == W_RUN);
  c_clkout_on: cover property ($rose(crystal_out_clock_pin_oe));
  c_power_cycle: cover property (s_reg.wake == W_RUN ##1 s_reg.wake == W_OFF);
  c_tune_write: cover property (bus_req.wr && bus_req.addr == ADDR_TUNE);
  c_divider_write: cover property (bus_req.wr && sys_rst_n && bus_req.addr == ADDR_DIVIDER);

endmodule
`default_nettype wire

// ---- tb/scg_osc_model.sv ----
// Far-side oscillators: watchdog, RC, crystal and external source, as ticks.
// Assumes periods are whole fabric cycles and every oscillator stops in power-down.
`timescale 1ns/10ps
`default_nettype none
module scg_osc_model #(
  parameter int P_WDT  = 4,
  parameter int P_RC   = 2,
  parameter int P_XTAL = 3,
  parameter int P_EXT  = 2
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       power_down,
  output var  scg_pkg::scg_osc_ticks_type osc_ticks
);
  import scg_pkg::*;
  // ==========================================================================
  // Oscillators
  // ==========================================================================
  // Ticks are registered so the block never sees a pulse that races its own edge.
  localparam int PER [4] = '{P_WDT, P_RC, P_XTAL, P_EXT};
  int cnt [4];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt       <= '{default: 0};
      osc_ticks <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt[i] <= (power_down || cnt[i] == PER[i] - 1) ? 0 : cnt[i] + 1;
      end
      osc_ticks.wdt  <= !power_down && cnt[0] == PER[0] - 1;
      osc_ticks.rc   <= !power_down && cnt[1] == PER[1] - 1;
      osc_ticks.xtal <= !power_down && cnt[2] == PER[2] - 1;
      osc_ticks.ext  <= !power_down && cnt[3] == PER[3] - 1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/system_clock_generation_test.sv ----
// Self-checking bench for the system clock generator with oscillator model.
// Assumes oscillator periods of a few fabric cycles and registered outputs.
`timescale 1ns/10ps
`default_nettype none
module system_clock_generation_test;
  import scg_pkg::*;
  localparam int P_WDT = 4;
  localparam int P_RC  = 2;
  localparam int P_XT  = 3;
  localparam int P_EXT = 2;
  logic              clk, rst_n, sys_rst_n, rtc_uses_crystal, power_down;
  logic [2:0]        config_source;
  logic [7:0]        factory_tune, bus_rdata, rc_tune_value;
  scg_osc_ticks_type osc_ticks;
  scg_bus_req_type   bus_req;
  logic              cpu_clock_tick, machine_cycle_tick, periph_clock_tick;
  logic              cpu_clock_running, pin_o, pin_oe;
  int                n_fail, n_compared, tune_m;
  logic [31:0]       seed;

  scg_osc_model #(.P_WDT(P_WDT), .P_RC(P_RC), .P_XTAL(P_XT), .P_EXT(P_EXT)) osc (
    .clk(clk), .rst_n(rst_n), .power_down(power_down), .osc_ticks(osc_ticks));
  scg_top uut (
    .clk(clk), .rst_n(rst_n), .sys_rst_n(sys_rst_n), .config_source(config_source),
    .factory_tune(factory_tune), .osc_ticks(osc_ticks), .rtc_uses_crystal(rtc_uses_crystal),
    .power_down(power_down), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .cpu_clock_tick(cpu_clock_tick), .machine_cycle_tick(machine_cycle_tick),
    .periph_clock_tick(periph_clock_tick), .cpu_clock_running(cpu_clock_running),
    .rc_tune_value(rc_tune_value), .crystal_out_clock_pin_o(pin_o),
    .crystal_out_clock_pin_oe(pin_oe));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int per_of(input logic [2:0] s);
    return s <= 3'h2 ? P_XT : s == SRC_WDT ? P_WDT : s == SRC_EXT ? P_EXT : P_RC;
  endfunction
  function automatic int wake_exp(input logic [2:0] s);
    return (s <= 3'h2 ? 992 : 224) * per_of(s) + 60000 / 50;
  endfunction
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask
  // The read data stand for one cycle only, so the cycle after is checked for zero.
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string name);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
    check(name, bus_rdata, exp);
    @(negedge clk);
    check("rdata_idle", bus_rdata, 8'h00);
  endtask
  task automatic por(input logic [2:0] src);
    logic [31:0] r;
    r = rnd();
    @(posedge clk);
    rst_n <= 1'b0;
    config_source <= src;
    factory_tune <= {2'b00, r[5:0]};
    tune_m = {2'b00, r[5:0]};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // Tolerance covers the latch cycles and the oscillator phase at start.
  task automatic wake(input int exp, input string name);
    int t;
    t = 0;
    while (cpu_clock_running !== 1'b1 && t < 8000) begin
      @(negedge clk);
      t++;
    end
    check(name, 32'(t >= exp - 8 && t <= exp + 8), 32'h1);
  endtask
  task automatic observe(input int gexp, input logic oe_exp);
    int c, m, p, tg, lt, ng, gbad, oe_bad;
    logic po;
    c = 0; m = 0; p = 0; tg = 0; lt = -1; ng = 0; gbad = 0; oe_bad = 0;
    repeat (4) @(posedge clk);
    po = pin_o;
    for (int t = 0; t < 8 * gexp + 40; t++) begin
      @(negedge clk);
      if (cpu_clock_tick === 1'b1) begin
        c++;
        if (lt >= 0) ng++;
        if (ng > 2 && t - lt != gexp) gbad++;
        lt = t;
      end
      if (machine_cycle_tick === 1'b1) m++;
      if (periph_clock_tick === 1'b1) p++;
      if (pin_o !== po) tg++;
      po = pin_o;
      if (pin_oe !== oe_exp) oe_bad++;
    end
    check("cpu_gap_errors", gbad, 0);
    check("machine_vs_cpu", 32'(2 * m >= c - 2 && 2 * m <= c + 2), 1);
    check("periph_vs_machine", p, m);
    check("clock_out_enable_errors", oe_bad, 0);
    check("clock_out_toggles", oe_exp ? 32'(tg >= c - 1 && tg <= c + 1) : tg, oe_exp);
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    end_sim();
  end
  initial begin
    logic [2:0]  srcs [6];
    int          f [5];
    int          k;
    logic [31:0] v;
    seed = 32'h0000002A;
    rst_n = 1'b0; sys_rst_n = 1'b1; rtc_uses_crystal = 1'b0; power_down = 1'b0;
    config_source = SRC_RC; factory_tune = 8'h00; bus_req = '0;
    n_fail = 0; n_compared = 0; tune_m = 0;
    srcs = '{SRC_XTAL_LOW, SRC_XTAL_MED, SRC_XTAL_HIGH, SRC_WDT, SRC_EXT, SRC_RC};
    foreach (srcs[i]) begin
      por(srcs[i]);
      wake(wake_exp(srcs[i]), "wake_cycles");
      check("tune_after_por", rc_tune_value, tune_m);
      tune_m = tune_m | 8'h40;
      wr(ADDR_TUNE, tune_m[7:0]);
      observe(per_of(srcs[i]), srcs[i] > 3'h2);
      $display("source %0d done", srcs[i]);
    end
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      wr(ADDR_TUNE, v[7:0]);
      tune_m = v[7:0];
      rdchk(ADDR_TUNE, tune_m[7:0], "tune_readback");
      check("tune_port", rc_tune_value, tune_m);
    end
    rdchk(8'h10, 8'h00, "unmapped_read");
    $display("tune test done");
    wr(ADDR_TUNE, 8'h15);
    tune_m = 8'h15;
    v = rnd();
    f = '{0, 1, 3, 32'(v[3:0]) + 2, 255};
    foreach (f[i]) begin
      wr(ADDR_DIVIDER, 8'(f[i]));
      observe(f[i] == 0 ? P_RC : 2 * f[i] * P_RC, 1'b0);
    end
    $display("divider test done");
    wr(ADDR_DIVIDER, 8'h01);
    wr(ADDR_TUNE, 8'h55);
    tune_m = 8'h55;
    observe(2 * P_RC, 1'b1);
    @(posedge clk);
    rtc_uses_crystal <= 1'b1;
    observe(2 * P_RC, 1'b0);
    @(posedge clk);
    rtc_uses_crystal <= 1'b0;
    $display("clock out test done");
    @(posedge clk);
    sys_rst_n <= 1'b0;
    wr(ADDR_TUNE, 8'h2A);
    @(posedge clk);
    sys_rst_n <= 1'b1;
    rdchk(ADDR_TUNE, tune_m[7:0], "tune_after_sys_reset");
    rdchk(ADDR_DIVIDER, DIVIDER_RESET, "divider_after_sys_reset");
    tune_m = tune_m & 8'hBF;
    wr(ADDR_TUNE, tune_m[7:0]);
    @(posedge clk);
    config_source <= SRC_XTAL_LOW;
    power_down <= 1'b1;
    repeat (4) @(posedge clk);
    k = 0;
    repeat (100) begin
      @(negedge clk);
      if (cpu_clock_tick !== 1'b0 || cpu_clock_running !== 1'b0) k++;
    end
    check("ticks_in_power_down", k, 0);
    @(posedge clk);
    power_down <= 1'b0;
    wake(wake_exp(SRC_RC), "wake_after_power_down");
    rdchk(ADDR_STATUS, 8'h1D, "status_after_wake");
    $display("power down test done");
    end_sim();
  end
endmodule
`default_nettype wire
